// file: bus_interface_config.sv
// Read-only bus interface configuration register reached through its alternate address space.
// What this block does
// - Register lives only at address space 4A hex, virtual address 0; read-only.
// - Supervisor reads return contents; writes are ignored with no side effect.
// - Bits 19:17 give level-2 size: 100=4 MB, 101=5 MB, 110=6 MB.
// - Bit 16 gives capacity per way: 0 is half a megabyte, 1 one megabyte.
// - Bits 15:11 give clock ratio; 0-11 reserved, 12 is 3:1, 30 is 7.5:1.
// - Bits 9:0 give the interrupt target identifier of the reading thread.
`default_nettype none
module bus_interface_config
    import bus_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic                            clk,
    input  wire logic                            reset,
    // Alternate-space access request from the load/store pipe.
    input  wire logic                            req_valid,
    input  wire logic                            req_write,
    input  wire logic                            req_supervisor,
    input  wire logic [7:0]                      req_asi,
    input  wire logic [63:0]                     req_va,
    input  wire logic [bus_cfg_pkg::THREAD_W-1:0] req_thread,
    // Configuration straps from pins.
    input  wire logic [bus_cfg_pkg::SIZE_W-1:0]  l2_total_size_code,
    input  wire logic                            l2_way_size_select,
    input  wire logic [bus_cfg_pkg::RATIO_W-1:0] clock_ratio_code,
    // Per-thread identifiers from same-clock logic.
    input  wire logic [bus_cfg_pkg::INTERRUPT_TARGET_ID_W-1:0]  interrupt_target_id [bus_cfg_pkg::THREADS],
    // Answer.
    output logic                                 rsp_valid,
    output logic                                 rsp_fault,
    output logic [63:0]                          rsp_rdata,
    // Status of the reported clock ratio.
    output logic                                 ratio_code_valid
);
    import bus_cfg_pkg::*;

    logic [SIZE_W-1:0]  size_sync;
    logic [RATIO_W-1:0] ratio_sync;
    logic               way_sync;
    logic [INTERRUPT_TARGET_ID_W-1:0]  interrupt_target_id_sel;
    logic               hit;
    logic [63:0]        word;
    logic               rsp_valid_reg;
    logic               rsp_valid_next;
    logic               rsp_fault_reg;
    logic               rsp_fault_next;
    logic [63:0]        rsp_rdata_reg;
    logic [63:0]        rsp_rdata_next;
    logic               ratio_valid_reg;
    logic               ratio_valid_next;

    // Straps come from pins, so each passes the three-stage filter.
    // The filter costs about four cycles after a pin settles; straps are fixed at power-up,
    // so the latency is harmless, but a read right after reset sees the filter's reset value.
    // The thread identifiers skip the filter because they already live on this clock.
    strap_sync #(.W(SIZE_W)) u_size_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (l2_total_size_code),
        .sync_out (size_sync)
    );
    strap_sync #(.W(1)) u_way_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (l2_way_size_select),
        .sync_out (way_sync)
    );
    strap_sync #(.W(RATIO_W)) u_ratio_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (clock_ratio_code),
        .sync_out (ratio_sync)
    );

    // Decode and word assembly; the identifier is picked per requesting thread.
    always_comb begin
        interrupt_target_id_sel = interrupt_target_id[req_thread];
        hit      = req_valid && (req_asi == CONFIG_ASI);
        word     = '0;
        word[SIZE_LSB +: SIZE_W]   = size_sync;
        word[WAY_BIT]              = way_sync;
        word[RATIO_LSB +: RATIO_W] = ratio_sync;
        word[INTERRUPT_TARGET_ID_LSB +: INTERRUPT_TARGET_ID_W]   = interrupt_target_id_sel;
    end

    // Answer logic. Writes are acknowledged with zero data and change nothing, because
    // there is no storage behind the word; a bad address or user read is flagged.
    // Every refused answer carries zero data, so nothing leaks to an unprivileged thread.
    // The answer is a single registered cycle; the pipe may request again at once.
    always_comb begin
        rsp_valid_next   = hit;
        rsp_fault_next   = 1'b0;
        rsp_rdata_next   = RDATA_RESET;
        if (hit && !req_write) begin
            if (req_supervisor && (req_va == CONFIG_VA)) begin
                rsp_rdata_next = word;
            end else begin
                rsp_fault_next = 1'b1;
            end
        end else if (hit && (req_va != CONFIG_VA)) begin
            rsp_fault_next = 1'b1;
        end
        // Codes below 3:1 or above 7.5:1 are reserved; between them the ratio is code divided by four.
        ratio_valid_next = (ratio_sync >= RATIO_MIN) && (ratio_sync <= RATIO_MAX);
    end

    // State registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsp_valid_reg   <= 1'b0;
            rsp_fault_reg   <= 1'b0;
            rsp_rdata_reg   <= RDATA_RESET;
            ratio_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg   <= rsp_valid_next;
            rsp_fault_reg   <= rsp_fault_next;
            rsp_rdata_reg   <= rsp_rdata_next;
            ratio_valid_reg <= ratio_valid_next;
        end
    end

    assign rsp_valid        = rsp_valid_reg;
    assign rsp_fault        = rsp_fault_reg;
    assign rsp_rdata        = rsp_rdata_reg;
    assign ratio_code_valid = ratio_valid_reg;

    // Checks on the answer.
    // All of them run on the core clock and rest while reset is high, so a
    // request cut by reset is neither answered nor checked. Expected fields are
    // taken from the filtered straps and from the raw identifier inputs, one
    // cycle back, because the answer is registered.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_other_space_silent: assert property (
        req_valid && (req_asi != CONFIG_ASI) |=> !rsp_valid)
        else $error("answer given for a foreign address space");
    a_read_returns_interrupt_target_id: assert property (
        hit && !req_write && req_supervisor && (req_va == CONFIG_VA)
        |=> rsp_valid && !rsp_fault && (rsp_rdata[9:0] == $past(interrupt_target_id_sel)))
        else $error("read did not return the thread identifier");
    a_write_ignored: assert property (
        hit && req_write && (req_va == CONFIG_VA) |=> rsp_valid && !rsp_fault && (rsp_rdata == 64'h0))
        else $error("write had a visible effect");
    a_user_read_fault: assert property (
        hit && !req_write && !req_supervisor |=> rsp_valid && rsp_fault && (rsp_rdata == 64'h0))
        else $error("user read was not refused");
    a_size_field: assert property (
        hit && !req_write && req_supervisor && (req_va == CONFIG_VA) |=> rsp_rdata[19:17] == $past(size_sync))
        else $error("size field wrong");
    a_way_field: assert property (
        hit && !req_write && req_supervisor && (req_va == CONFIG_VA) |=> rsp_rdata[16] == $past(way_sync))
        else $error("way field wrong");
    a_ratio_field: assert property (
        hit && !req_write && req_supervisor && (req_va == CONFIG_VA) |=> rsp_rdata[15:11] == $past(ratio_sync))
        else $error("ratio field wrong");
    a_reserved_zero: assert property (
        rsp_valid |-> (rsp_rdata[63:20] == 44'h0) && !rsp_rdata[10])
        else $error("reserved bits not zero");
    a_ratio_valid_flag: assert property (
        ##1 ratio_code_valid == ($past(ratio_sync) >= 5'h0c && $past(ratio_sync) <= 5'h1e))
        else $error("ratio status wrong");

    // Only an access to the register's space may be answered.
    a_answer_needs_hit: assert property (
        !hit |=> !rsp_valid)
        else $error("answer without an accepted request");

    // Every accepted access is answered in the next cycle.
    a_hit_answered: assert property (
        hit |=> rsp_valid)
        else $error("accepted request not answered");

    // Any address other than zero in this space is refused.
    a_bad_va_fault: assert property (
        hit && (req_va != CONFIG_VA) |=> rsp_fault)
        else $error("bad address not refused");

    // A refusal never carries data.
    a_fault_data_zero: assert property (
        rsp_fault |-> (rsp_rdata == 64'h0))
        else $error("refused answer carried data");

    // A fault is only shown together with an answer.
    a_fault_only_on_hit: assert property (
        rsp_fault |-> rsp_valid)
        else $error("fault without an answer");

    // Between answers the outputs rest at zero.
    a_idle_outputs_clear: assert property (
        !rsp_valid |-> !rsp_fault && (rsp_rdata == 64'h0))
        else $error("outputs not clear while idle");

    // A write returns no data, whatever its address.
    a_write_no_data: assert property (
        hit && req_write |=> (rsp_rdata == 64'h0))
        else $error("write returned data");

    // The identifier comes from the requesting thread's own input.
    a_thread_select: assert property (
        hit && !req_write && req_supervisor && (req_va == CONFIG_VA)
        |=> rsp_rdata[INTERRUPT_TARGET_ID_W-1:0] == $past(interrupt_target_id[req_thread]))
        else $error("identifier of another thread returned");

    // The ratio status never claims a code above the last defined one.
    a_ratio_flag_range: assert property (
        ##1 ratio_code_valid |-> ($past(ratio_sync) <= RATIO_MAX))
        else $error("ratio status set for an undefined code");

    c_good_read: cover property (rsp_valid && !rsp_fault && rsp_rdata != 64'h0);
    c_write: cover property (hit && req_write ##1 rsp_valid);
    c_fault: cover property (rsp_valid && rsp_fault);
    c_back_to_back: cover property (rsp_valid [*2]);
    c_user_write: cover property (hit && req_write && !req_supervisor);
endmodule : bus_interface_config
`default_nettype wire

// file: bus_cfg_pkg.sv
// Package with the constants of the bus interface configuration register.
`default_nettype none
package bus_cfg_pkg;
    // Access decode.
    localparam logic [7:0]  CONFIG_ASI        = 8'h4a;
    localparam logic [63:0] CONFIG_VA         = 64'h0;
    // Thread count and identifier width.
    localparam int          THREADS           = 8;
    localparam int          THREAD_W          = 3;
    localparam int          INTERRUPT_TARGET_ID_W            = 10;
    // Field positions inside the 64-bit word.
    localparam int          INTERRUPT_TARGET_ID_LSB          = 0;
    localparam int          RATIO_LSB         = 11;
    localparam int          RATIO_W           = 5;
    localparam int          WAY_BIT           = 16;
    localparam int          SIZE_LSB          = 17;
    localparam int          SIZE_W            = 3;
    localparam int          RESERVED_LSB      = 20;
    localparam int          GAP_BIT           = 10;
    // Defined codes; the ratio code counts in quarters, so code 12 is 3:1.
    localparam logic [2:0]  SIZE_4MB          = 3'h4;
    localparam logic [2:0]  SIZE_5MB          = 3'h5;
    localparam logic [2:0]  SIZE_6MB          = 3'h6;
    localparam logic [4:0]  RATIO_MIN         = 5'h0c;
    localparam logic [4:0]  RATIO_MAX         = 5'h1e;
    // Reset values of the synchronised straps and of the answer.
    localparam logic [2:0]  SIZE_RESET        = 3'h0;
    localparam logic        WAY_RESET         = 1'b0;
    localparam logic [4:0]  RATIO_RESET       = 5'h00;
    localparam logic [63:0] RDATA_RESET       = 64'h0;
endpackage : bus_cfg_pkg
`default_nettype wire

// file: strap_sync.sv
// Three-stage synchroniser that accepts a value once the last two stages agree.
`default_nettype none
module strap_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Asynchronous input and filtered output.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // The output moves only when stages two and three agree, so a glitch is not taken.
    always_comb begin
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end

    // Only the second stage reads the first one.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule : strap_sync
`default_nettype wire

// file: bus_interface_config_tb.sv
// Self-checking testbench of the bus interface configuration register.
`default_nettype none
module bus_interface_config_tb
    import bus_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  asi;
        logic [63:0] va;
        logic        wr;
        logic        sup;
        logic [2:0]  thr;
        logic [2:0]  size;
        logic        way;
        logic [4:0]  ratio;
    } row_t;
    logic clk, reset, req_valid, req_write, req_supervisor, l2_way_size_select;
    logic [7:0] req_asi;
    logic [63:0] req_va, rsp_rdata;
    logic [THREAD_W-1:0] req_thread;
    logic [SIZE_W-1:0] l2_total_size_code;
    logic [RATIO_W-1:0] clock_ratio_code;
    logic [INTERRUPT_TARGET_ID_W-1:0] ids [THREADS];
    logic rsp_valid, rsp_fault, ratio_code_valid;
    int fails = 0;
    int checks_done = 0;
    // Each row sets the straps, then makes one access; rows five to nine cover refusals, writes and a foreign space.
    row_t rows [10] = '{
        '{8'h4a, 64'h0, 1'b0, 1'b1, 3'h0, 3'h4, 1'b0, 5'h0c}, '{8'h4a, 64'h0, 1'b0, 1'b1, 3'h7, 3'h5, 1'b1, 5'h1e},
        '{8'h4a, 64'h0, 1'b0, 1'b1, 3'h3, 3'h6, 1'b1, 5'h0b}, '{8'h4a, 64'h0, 1'b0, 1'b1, 3'h5, 3'h6, 1'b0, 5'h1f},
        '{8'h4a, 64'h0, 1'b0, 1'b0, 3'h1, 3'h4, 1'b1, 5'h0d}, '{8'h4a, 64'h8, 1'b0, 1'b1, 3'h2, 3'h5, 1'b0, 5'h0e},
        '{8'h4a, 64'h0, 1'b1, 1'b1, 3'h4, 3'h6, 1'b1, 5'h10}, '{8'h4a, 64'h8000000000000000, 1'b1, 1'b0, 3'h6, 3'h4, 1'b0, 5'h14},
        '{8'h4b, 64'h0, 1'b0, 1'b1, 3'h2, 3'h5, 1'b1, 5'h00}, '{8'h4a, 64'h0, 1'b0, 1'b1, 3'h2, 3'h5, 1'b1, 5'h0d}};

    bus_interface_config uut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
        .req_supervisor(req_supervisor), .req_asi(req_asi), .req_va(req_va), .req_thread(req_thread),
        .l2_total_size_code(l2_total_size_code), .l2_way_size_select(l2_way_size_select),
        .clock_ratio_code(clock_ratio_code), .interrupt_target_id(ids), .rsp_valid(rsp_valid),
        .rsp_fault(rsp_fault), .rsp_rdata(rsp_rdata), .ratio_code_valid(ratio_code_valid));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check1(input string name, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", name, e, g);
        end
    endtask

    task automatic check64(input string name, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask

    // Raises one request just after an edge; the caller lowers or replaces it at the next edge.
    task automatic issue(input row_t r);
        @(posedge clk);
        req_valid <= 1'b1;
        req_asi <= r.asi;
        req_va <= r.va;
        req_write <= r.wr;
        req_supervisor <= r.sup;
        req_thread <= r.thr;
    endtask

    // Expected answer is built from the straps the bench drives, never from the outputs.
    task automatic expect_row(input row_t r);
        logic f;
        logic [63:0] d;
        f = (r.va != 64'h0) || (!r.wr && !r.sup);
        d = (!r.wr && !f) ? {44'h0, l2_total_size_code, l2_way_size_select, clock_ratio_code, 1'b0, ids[r.thr]} : 64'h0;
        check1("rsp_valid", r.asi == CONFIG_ASI, rsp_valid);
        if (r.asi == CONFIG_ASI) begin
            check1("rsp_fault", f, rsp_fault);
            check64("rsp_rdata", d, rsp_rdata);
        end
    endtask

    task automatic stop_test;
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the roughly 150 cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_supervisor = 1'b0;
        req_asi = 8'h0;
        req_va = 64'h0;
        req_thread = 3'h0;
        l2_total_size_code = 3'h0;
        l2_way_size_select = 1'b0;
        clock_ratio_code = 5'h0;
        for (int i = 0; i < THREADS; i++) ids[i] = 10'(i * 73 + 5);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        // Table loop; ten cycles let the strap filter settle after each change.
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            l2_total_size_code <= rows[i].size;
            l2_way_size_select <= rows[i].way;
            clock_ratio_code <= rows[i].ratio;
            repeat (10) @(posedge clk);
            #1 check1("ratio_code_valid", rows[i].ratio >= RATIO_MIN && rows[i].ratio <= RATIO_MAX, ratio_code_valid);
            issue(rows[i]);
            @(posedge clk);
            req_valid <= 1'b0;
            #1 expect_row(rows[i]);
        end
        // Back to back: write, then reads that must still see the unchanged word.
        issue(rows[6]);
        issue(rows[0]);
        #1 expect_row(rows[6]);
        issue(rows[1]);
        #1 expect_row(rows[0]);
        @(posedge clk);
        req_valid <= 1'b0;
        #1 expect_row(rows[1]);
        // Reset in mid-request: no answer, outputs cleared.
        issue(rows[0]);
        reset <= 1'b1;
        #1 check1("ratio_code_valid", 1'b0, ratio_code_valid);
        @(posedge clk);
        #1 check1("rsp_valid", 1'b0, rsp_valid);
        @(posedge clk);
        reset <= 1'b0;
        req_valid <= 1'b0;
        repeat (10) @(posedge clk);
        issue(rows[1]);
        @(posedge clk);
        req_valid <= 1'b0;
        #1 expect_row(rows[1]);
        stop_test();
    end
endmodule // bus_interface_config_tb
`default_nettype wire
